// [src/dtc_pkg.sv]
// Package with register map, field positions and timing constants for the dual timer
`default_nettype none
package dtc_pkg;
	// Register bus widths
	localparam int ADDR_W = 3;
	localparam int DATA_W = 8;
	// Register offsets
	localparam logic [2:0] ADDR_MODE     = 3'h0; // timer_mode_register
	localparam logic [2:0] ADDR_CTRL     = 3'h1; // timer_control_register
	localparam logic [2:0] ADDR_LOW_ZERO = 3'h2; // timer_zero_low_byte
	localparam logic [2:0] ADDR_LOW_ONE  = 3'h3;
	localparam logic [2:0] ADDR_HI_ZERO  = 3'h4; // timer_zero_high_byte
	localparam logic [2:0] ADDR_HI_ONE   = 3'h5;
	localparam logic [2:0] ADDR_TOGGLE   = 3'h6; // port_two_mode_register
	// Mode register fields
	localparam int GATE_ONE_BIT = 7;
	localparam int CT_ONE_BIT   = 6;
	localparam int MODE_ONE_LSB = 4;
	localparam int GATE_ZERO_BIT = 3;
	localparam int CT_ZERO_BIT   = 2;
	localparam int MODE_ZERO_LSB = 0;
	// Control register fields
	localparam int OVF_ONE_BIT  = 7;
	localparam int RUN_ONE_BIT  = 6;
	localparam int OVF_ZERO_BIT = 5;
	localparam int RUN_ZERO_BIT = 4;
	// Toggle enable register fields
	localparam int TOG_ZERO_BIT = 0;
	localparam int TOG_ONE_BIT  = 1;
	// Reset values
	localparam logic [7:0] RST_BYTE   = 8'h00;
	localparam logic       RST_TOGGLE = 1'b1;
	// CPU clocks per machine cycle
	localparam int MC_CLOCKS = 6;
	// Operating modes
	typedef enum logic [1:0] {
		DTC_MODE_13BIT  = 2'h0,
		DTC_MODE_16BIT  = 2'h1,
		DTC_MODE_RELOAD = 2'h2,
		DTC_MODE_SPLIT  = 2'h3
	} dtc_mode_t;
endpackage
`default_nettype wire

// [src/dtc_timer.sv]
// Dual timer/counter with gate, four modes, toggle outputs and baud tick
//
// Behaviour
// - Timer function counts once per machine cycle of six CPU clocks.
// - Counter function samples count pin per machine cycle, counts on high-then-low.
// - Count updates in machine cycle after edge detection; two cycles per edge.
// - Per-timer select bit picks timer/counter; two-bit field picks mode.
// - Mode 0 is 13 bits: high byte plus low five low-byte bits.
// - Rollover from all ones to zeros sets the overflow flag.
// - Counting only while run bit set and gate clear or interrupt pin high; timer one with timer zero in mode 3 ignores run bit and gate.
// - Gate bit of timer one at mode bit 7, timer zero at bit 3.
// - Setting the run bit leaves the count bytes untouched.
// - Mode 1 is a full 16-bit counter.
// - Mode 2 counts low byte, reloads it from high byte on overflow.
// - Timer one in mode 3 stops as if run bit cleared.
// - Timer zero mode 3 low byte uses timer zero's controls and flag.
// - Timer zero mode 3 high byte counts cycles with timer one run and flag.
// - With timer zero in mode 3, timer one still counts for baud.
// - Toggle enable inverts the count pin output on each overflow.
// - Toggle output drives 1 until the first overflow.
// - Timer one overflow supplies the serial port baud tick.
//
// The implementer's own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ns
`default_nettype none

module dtc_timer #(
	parameter int MC_DIV = dtc_pkg::MC_CLOCKS
) (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       nrst,
	// Register port
	input  wire logic [2:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	// Count pins, two-way
	input  wire logic       count_pin_zero_i,
	output logic            count_pin_zero_o,
	output logic            count_pin_zero_oe,
	input  wire logic       count_pin_one_i,
	output logic            count_pin_one_o,
	output logic            count_pin_one_oe,
	// External interrupt pins used as gates
	input  wire logic       external_interrupt_pin_zero,
	input  wire logic       external_interrupt_pin_one,
	// Interrupt controller
	input  wire logic       irq_ack_zero,
	input  wire logic       irq_ack_one,
	output logic            timer_zero_overflow,
	output logic            timer_one_overflow,
	// Serial port baud source
	output logic            baud_tick
);

	// Divider is eight bits wide and needs at least two clocks
	if (MC_DIV < 2 || MC_DIV > 255) begin
		$error("MC_DIV out of range");
	end

	////////////////////////////////////////////////////////////////////////////////
	// Declarations
	logic [7:0] mode_r;
	logic       run_zero_r;
	logic       run_one_r;
	logic       ovf_zero_r;
	logic       ovf_one_r;
	logic       tog_en_zero_r;
	logic       tog_en_one_r;
	logic [7:0] low_zero_r;
	logic [7:0] high_zero_r;
	logic [7:0] low_one_r;
	logic [7:0] high_one_r;
	logic       tog_zero_r;
	logic       tog_one_r;
	logic [7:0] mc_cnt_r;
	logic       mc_en;
	logic [3:0] s1_r;
	logic [3:0] s2_r;
	logic [3:0] s3_r;
	logic [3:0] filt_r;
	logic [1:0] samp_r;
	logic [1:0] samp_prev_r;
	logic [1:0] fall;
	logic       int_zero;
	logic       int_one;
	logic [1:0] mode_zero;
	logic [1:0] mode_one;
	logic       split_zero;
	logic       run_zero;
	logic       run_one;
	logic       tick_zero;
	logic       tick_one;
	logic       tick_high;
	logic [16:0] step_zero;
	logic [16:0] step_one;
	logic       ovf_zero;
	logic       ovf_one;
	logic       ovf_high;
	logic       set_flag_one;
	logic       wr_mode;
	logic       wr_ctrl;
	logic       wr_low_zero;
	logic       wr_high_zero;
	logic       wr_low_one;
	logic       wr_high_one;
	logic       wr_tog;

	////////////////////////////////////////////////////////////////////////////////
	// Count step: returns {overflow, high, low}
	function automatic logic [16:0] dtc_step(input logic [1:0] m, input logic [7:0] hi,
		input logic [7:0] lo);
		logic [13:0] c13;
		logic [16:0] c16;
		logic [8:0]  c8;
		begin
			c13 = {1'b0, hi, lo[4:0]} + 14'h0001;
			c16 = {1'b0, hi, lo} + 17'h00001;
			c8  = {1'b0, lo} + 9'h001;
			case (m)
				2'h0: dtc_step = {c13[13], c13[12:5], lo[7:5], c13[4:0]};
				2'h1: dtc_step = c16;
				2'h2: dtc_step = {c8[8], hi, (c8[8] ? hi : c8[7:0])};
				default: dtc_step = {c8[8], hi, c8[7:0]};
			endcase
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Write decode
	assign wr_mode      = reg_wr && reg_addr == dtc_pkg::ADDR_MODE;
	assign wr_ctrl      = reg_wr && reg_addr == dtc_pkg::ADDR_CTRL;
	assign wr_low_zero  = reg_wr && reg_addr == dtc_pkg::ADDR_LOW_ZERO;
	assign wr_high_zero = reg_wr && reg_addr == dtc_pkg::ADDR_HI_ZERO;
	assign wr_low_one   = reg_wr && reg_addr == dtc_pkg::ADDR_LOW_ONE;
	assign wr_high_one  = reg_wr && reg_addr == dtc_pkg::ADDR_HI_ONE;
	assign wr_tog       = reg_wr && reg_addr == dtc_pkg::ADDR_TOGGLE;

	// Machine cycle divider
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			mc_cnt_r <= 8'h00;
		end else if (mc_cnt_r == 8'(MC_DIV - 1)) begin
			mc_cnt_r <= 8'h00;
		end else begin
			mc_cnt_r <= mc_cnt_r + 8'h01;
		end
	end
	assign mc_en = (mc_cnt_r == 8'(MC_DIV - 1));

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers: bit0 count zero, bit1 count one, bit2/3 interrupt pins
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s1_r   <= 4'h0;
			s2_r   <= 4'h0;
			s3_r   <= 4'h0;
			filt_r <= 4'h0;
		end else begin
			s1_r   <= {external_interrupt_pin_one, external_interrupt_pin_zero,
				count_pin_one_i, count_pin_zero_i};
			s2_r   <= s1_r;
			s3_r   <= s2_r;
			filt_r <= (s2_r & ~(s2_r ^ s3_r)) | (filt_r & (s2_r ^ s3_r));
		end
	end
	assign int_zero = filt_r[2];
	assign int_one  = filt_r[3];

	// Count pin sampling once per machine cycle
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			samp_r      <= 2'h0;
			samp_prev_r <= 2'h0;
		end else if (mc_en) begin
			samp_r      <= filt_r[1:0];
			samp_prev_r <= samp_r;
		end
	end
	// Edge seen one cycle, counted at the next machine cycle
	assign fall = {2{mc_en}} & samp_prev_r & ~samp_r;

	////////////////////////////////////////////////////////////////////////////////
	// Mode, run and gate decoding
	assign mode_zero  = mode_r[dtc_pkg::MODE_ZERO_LSB +: 2];
	assign mode_one   = mode_r[dtc_pkg::MODE_ONE_LSB +: 2];
	assign split_zero = (mode_zero == dtc_pkg::DTC_MODE_SPLIT);
	assign run_zero   = run_zero_r && (!mode_r[dtc_pkg::GATE_ZERO_BIT] || int_zero);
	// Timer one: own mode 3 stops it; under split it ignores its run bit
	assign run_one    = (mode_one != dtc_pkg::DTC_MODE_SPLIT) && (split_zero ||
		(run_one_r && (!mode_r[dtc_pkg::GATE_ONE_BIT] || int_one)));
	assign tick_zero  = run_zero && (mode_r[dtc_pkg::CT_ZERO_BIT] ? fall[0] : mc_en);
	assign tick_one   = run_one && (mode_r[dtc_pkg::CT_ONE_BIT] ? fall[1] : mc_en);
	assign tick_high  = split_zero && run_one_r && mc_en;

	always_comb begin
		step_zero = dtc_step(mode_zero, high_zero_r, low_zero_r);
		step_one  = dtc_step(mode_one, high_one_r, low_one_r);
	end
	assign ovf_zero     = tick_zero && step_zero[16];
	assign ovf_one      = tick_one && step_one[16];
	assign ovf_high     = tick_high && high_zero_r == 8'hFF;
	assign set_flag_one = split_zero ? ovf_high : ovf_one;

	////////////////////////////////////////////////////////////////////////////////
	// Timer zero count bytes, a bus write wins over a count
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			low_zero_r  <= dtc_pkg::RST_BYTE;
			high_zero_r <= dtc_pkg::RST_BYTE;
		end else begin
			if (wr_low_zero) begin
				low_zero_r <= reg_wdata;
			end else if (tick_zero) begin
				low_zero_r <= step_zero[7:0];
			end
			if (wr_high_zero) begin
				high_zero_r <= reg_wdata;
			end else if (tick_high) begin
				high_zero_r <= high_zero_r + 8'h01;
			end else if (tick_zero && !split_zero) begin
				high_zero_r <= step_zero[15:8];
			end
		end
	end

	// Timer one count bytes
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			low_one_r  <= dtc_pkg::RST_BYTE;
			high_one_r <= dtc_pkg::RST_BYTE;
		end else begin
			if (wr_low_one) begin
				low_one_r <= reg_wdata;
			end else if (tick_one) begin
				low_one_r <= step_one[7:0];
			end
			if (wr_high_one) begin
				high_one_r <= reg_wdata;
			end else if (tick_one) begin
				high_one_r <= step_one[15:8];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Mode, run and toggle-enable registers; run writes touch no count
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			mode_r        <= dtc_pkg::RST_BYTE;
			run_zero_r    <= 1'b0;
			run_one_r     <= 1'b0;
			tog_en_zero_r <= 1'b0;
			tog_en_one_r  <= 1'b0;
		end else begin
			if (wr_mode) begin
				mode_r <= reg_wdata;
			end
			if (wr_ctrl) begin
				run_zero_r <= reg_wdata[dtc_pkg::RUN_ZERO_BIT];
				run_one_r  <= reg_wdata[dtc_pkg::RUN_ONE_BIT];
			end
			if (wr_tog) begin
				tog_en_zero_r <= reg_wdata[dtc_pkg::TOG_ZERO_BIT];
				tog_en_one_r  <= reg_wdata[dtc_pkg::TOG_ONE_BIT];
			end
		end
	end

	// Overflow flags: hardware set wins over software write or acknowledge
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ovf_zero_r <= 1'b0;
			ovf_one_r  <= 1'b0;
		end else begin
			if (ovf_zero) begin
				ovf_zero_r <= 1'b1;
			end else if (wr_ctrl) begin
				ovf_zero_r <= reg_wdata[dtc_pkg::OVF_ZERO_BIT];
			end else if (irq_ack_zero) begin
				ovf_zero_r <= 1'b0;
			end
			if (set_flag_one) begin
				ovf_one_r <= 1'b1;
			end else if (wr_ctrl) begin
				ovf_one_r <= reg_wdata[dtc_pkg::OVF_ONE_BIT];
			end else if (irq_ack_one) begin
				ovf_one_r <= 1'b0;
			end
		end
	end
	assign timer_zero_overflow = ovf_zero_r;
	assign timer_one_overflow  = ovf_one_r;

	////////////////////////////////////////////////////////////////////////////////
	// Toggle outputs: held at 1 while disabled, inverted on overflow
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			tog_zero_r <= dtc_pkg::RST_TOGGLE;
			tog_one_r  <= dtc_pkg::RST_TOGGLE;
		end else begin
			if (!tog_en_zero_r) begin
				tog_zero_r <= dtc_pkg::RST_TOGGLE;
			end else if (ovf_zero) begin
				tog_zero_r <= !tog_zero_r;
			end
			if (!tog_en_one_r) begin
				tog_one_r <= dtc_pkg::RST_TOGGLE;
			end else if (ovf_one) begin
				tog_one_r <= !tog_one_r;
			end
		end
	end
	assign count_pin_zero_o  = tog_zero_r;
	assign count_pin_zero_oe = tog_en_zero_r;
	assign count_pin_one_o   = tog_one_r;
	assign count_pin_one_oe  = tog_en_one_r;

	// Baud tick to serial port, one cycle per timer one overflow
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			baud_tick <= 1'b0;
		end else begin
			baud_tick <= ovf_one;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read port, data in the cycle after the strobe
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				dtc_pkg::ADDR_MODE:     reg_rdata <= mode_r;
				dtc_pkg::ADDR_CTRL:     reg_rdata <= {ovf_one_r, run_one_r, ovf_zero_r,
					run_zero_r, 4'h0};
				dtc_pkg::ADDR_LOW_ZERO: reg_rdata <= low_zero_r;
				dtc_pkg::ADDR_HI_ZERO:  reg_rdata <= high_zero_r;
				dtc_pkg::ADDR_LOW_ONE:  reg_rdata <= low_one_r;
				dtc_pkg::ADDR_HI_ONE:   reg_rdata <= high_one_r;
				dtc_pkg::ADDR_TOGGLE:   reg_rdata <= {6'h00, tog_en_one_r, tog_en_zero_r};
				default:                reg_rdata <= 8'h00;
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Assertions
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	mc_period_a: assert property (mc_en |=> !mc_en [*5] ##1 mc_en)
		else $error("machine cycle enable not every six clocks");
	tick_on_mc_a: assert property ((tick_zero || tick_one) |-> mc_en)
		else $error("count outside machine cycle");
	gate_hold_a: assert property (tick_zero |->
		run_zero_r && (!mode_r[3] || int_zero))
		else $error("timer zero counted while gated");
	one_stop_a: assert property (mode_one == 2'h3 |-> !tick_one)
		else $error("timer one counted in mode 3");
	flag_set_a: assert property (ovf_zero |=> ovf_zero_r)
		else $error("overflow flag not set");
	flag_hold_a: assert property (ovf_zero_r && !wr_ctrl && !irq_ack_zero |=> ovf_zero_r)
		else $error("overflow flag dropped");
	reload_a: assert property (mode_zero == 2'h2 && ovf_zero && !wr_low_zero &&
		!wr_high_zero |=> low_zero_r == $past(high_zero_r) && ovf_zero_r)
		else $error("mode 2 reload wrong");
	wrap16_a: assert property (mode_zero == 2'h1 && tick_zero && !wr_low_zero &&
		!wr_high_zero && &{high_zero_r, low_zero_r} |=> {high_zero_r, low_zero_r} == 16'h0000)
		else $error("16-bit wrap wrong");
	wrap13_a: assert property (mode_zero == 2'h0 && tick_zero &&
		high_zero_r == 8'hFF && low_zero_r[4:0] == 5'h1F && !wr_low_zero && !wr_high_zero
		|=> high_zero_r == 8'h00 && low_zero_r[4:0] == 5'h00 && ovf_zero_r)
		else $error("13-bit wrap wrong");
	split_high_a: assert property (tick_high && high_zero_r == 8'hFF &&
		!wr_high_zero |=> high_zero_r == 8'h00 && ovf_one_r)
		else $error("split high byte overflow wrong");
	toggle_flip_a: assert property (tog_en_zero_r && ovf_zero && !wr_tog
		|=> count_pin_zero_o != $past(count_pin_zero_o))
		else $error("toggle output did not invert");
	toggle_init_a: assert property ($rose(tog_en_one_r) |-> count_pin_one_o)
		else $error("toggle output not at one before overflow");
	baud_a: assert property (ovf_one |=> baud_tick)
		else $error("baud tick missing");

	reload_c: cover property (mode_zero == 2'h2 && ovf_zero);
	counter_c: cover property (mode_r[2] && tick_zero);
	split_c: cover property (ovf_high);
	toggle_c: cover property (tog_en_one_r && ovf_one);

endmodule

`default_nettype wire

// [test/dtc_far_model.sv]
// Far-side model: count pins, gate pins and baud tick consumer
`timescale 1ns/1ns
`default_nettype none

module dtc_far_model (
	// Clock
	input  wire logic       clk,
	// Timer pin drivers and baud tick
	input  wire logic       pin_zero_o,
	input  wire logic       pin_zero_oe,
	input  wire logic       pin_one_o,
	input  wire logic       pin_one_oe,
	input  wire logic       baud_tick,
	// Wire levels, gates and measured baud gap
	output logic            pin_zero_lvl,
	output logic            pin_one_lvl,
	output var logic        gate_zero,
	output var logic        gate_one,
	output var logic  [7:0] baud_gap
);
	logic       drv_zero;
	logic       drv_one;
	logic [7:0] gap_cnt;

	// Timer output wins while enabled, the model's own drive level otherwise
	assign pin_zero_lvl = pin_zero_oe ? pin_zero_o : drv_zero;
	assign pin_one_lvl  = pin_one_oe ? pin_one_o : drv_one;

	// Idle levels
	initial begin
		drv_zero = 1'b1;
		drv_one = 1'b1;
		gate_zero = 1'b0;
		gate_one = 1'b0;
		baud_gap = 8'h00;
		gap_cnt = 8'h00;
	end

	// Clocks between baud ticks, as a serial port divider sees them
	always @(posedge clk) begin
		if (baud_tick === 1'b1) begin
			baud_gap <= gap_cnt + 8'h01;
			gap_cnt <= 8'h00;
		end else begin
			gap_cnt <= gap_cnt + 8'h01;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Falling edges on count pin zero, each level held for hold clocks
	task automatic fall_edges(input int n, input int hold);
		for (int i = 0; i < n; i++) begin
			drv_zero <= 1'b1;
			repeat (hold) @(posedge clk);
			drv_zero <= 1'b0;
			repeat (hold) @(posedge clk);
		end
	endtask

	// Gate pin levels
	task automatic set_gates(input logic g0, input logic g1);
		gate_zero <= g0;
		gate_one <= g1;
	endtask
endmodule

`default_nettype wire

// [test/dual_timer_counter_with_toggle_tb_top.sv]
// Self-checking bench for the dual timer/counter
`timescale 1ns/1ns
`default_nettype none

module dual_timer_counter_with_toggle_tb_top;
	localparam int MC = dtc_pkg::MC_CLOCKS;
	logic       clk;
	logic       nrst;
	logic [2:0] reg_addr;
	logic [7:0] reg_wdata;
	logic       reg_wr;
	logic       reg_rd;
	logic [7:0] reg_rdata;
	logic       pz_i, pz_o, pz_oe, po_i, po_o, po_oe;
	logic       gate_zero, gate_one, ack_zero, ack_one;
	logic       timer_zero_overflow, timer_one_overflow, baud_tick;
	logic [7:0] baud_gap;
	int         n_fail, check_count, cycles;

	dtc_timer #(.MC_DIV(MC)) i_dtc_timer (.clk(clk), .nrst(nrst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.count_pin_zero_i(pz_i), .count_pin_zero_o(pz_o), .count_pin_zero_oe(pz_oe),
		.count_pin_one_i(po_i), .count_pin_one_o(po_o), .count_pin_one_oe(po_oe),
		.external_interrupt_pin_zero(gate_zero), .external_interrupt_pin_one(gate_one),
		.irq_ack_zero(ack_zero), .irq_ack_one(ack_one),
		.timer_zero_overflow(timer_zero_overflow), .timer_one_overflow(timer_one_overflow),
		.baud_tick(baud_tick));

	dtc_far_model i_dtc_far_model (.clk(clk), .pin_zero_o(pz_o), .pin_zero_oe(pz_oe),
		.pin_one_o(po_o), .pin_one_oe(po_oe), .baud_tick(baud_tick), .pin_zero_lvl(pz_i),
		.pin_one_lvl(po_i), .gate_zero(gate_zero), .gate_one(gate_one), .baud_gap(baud_gap));

	// Clock
	initial clk = 1'b0;
	always #4 clk = ~clk;

	// Hang guard
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 6000) begin
			n_fail++;
			wrap_up();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register bus, compare and wait helpers
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		@(posedge clk);
	endtask

	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp, input logic [7:0] msk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(posedge clk);
		chk8(reg_rdata & msk, exp);
	endtask

	task automatic wait_flag(input logic sel, input int lim);
		for (int i = 0; i < lim; i++) begin
			@(posedge clk);
			if ((sel ? timer_one_overflow : timer_zero_overflow) === 1'b1) break;
		end
		chk8({7'h00, sel ? timer_one_overflow : timer_zero_overflow}, 8'h01);
	endtask

	task automatic ack(input logic sel);
		ack_zero <= ~sel;
		ack_one <= sel;
		@(posedge clk);
		ack_zero <= 1'b0;
		ack_one <= 1'b0;
		@(posedge clk);
	endtask

	task automatic setup(input logic [7:0] mode, input logic [7:0] lo0, input logic [7:0] hi0);
		wr(dtc_pkg::ADDR_CTRL, 8'h00);
		wr(dtc_pkg::ADDR_MODE, mode);
		wr(dtc_pkg::ADDR_LOW_ZERO, lo0);
		wr(dtc_pkg::ADDR_HI_ZERO, hi0);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_reset();
		for (int a = 0; a < 8; a++) rd_chk(3'(a), 8'h00, 8'hFF);
		chk8({4'h0, po_o, po_oe, pz_o, pz_oe}, 8'h0A);
	endtask

	task automatic t_gate_run();
		setup(8'h09, 8'hFE, 8'hFF);
		wr(dtc_pkg::ADDR_CTRL, 8'h10);
		repeat (30) @(posedge clk);
		rd_chk(dtc_pkg::ADDR_LOW_ZERO, 8'hFE, 8'hFF);
		i_dtc_far_model.set_gates(1'b1, 1'b0);
		wait_flag(1'b0, 40);
		rd_chk(dtc_pkg::ADDR_HI_ZERO, 8'h00, 8'hFF);
	endtask

	// Timer one gated by its own pin through mode bit 7
	task automatic t_gate_one();
		wr(dtc_pkg::ADDR_CTRL, 8'h00);
		wr(dtc_pkg::ADDR_MODE, 8'h90);
		wr(dtc_pkg::ADDR_LOW_ONE, 8'hFE);
		wr(dtc_pkg::ADDR_HI_ONE, 8'hFF);
		wr(dtc_pkg::ADDR_CTRL, 8'h40);
		repeat (30) @(posedge clk);
		rd_chk(dtc_pkg::ADDR_LOW_ONE, 8'hFE, 8'hFF);
		i_dtc_far_model.set_gates(1'b1, 1'b1);
		wait_flag(1'b1, 40);
		rd_chk(dtc_pkg::ADDR_HI_ONE, 8'h00, 8'hFF);
	endtask

	task automatic t_mode0();
		setup(8'h00, 8'h1F, 8'hFF);
		wr(dtc_pkg::ADDR_CTRL, 8'h10);
		wait_flag(1'b0, 30);
		rd_chk(dtc_pkg::ADDR_HI_ZERO, 8'h00, 8'hFF);
	endtask

	task automatic t_flags();
		wr(dtc_pkg::ADDR_CTRL, 8'h20);
		repeat (10) @(posedge clk);
		chk8({7'h00, timer_zero_overflow}, 8'h01);
		ack(1'b0);
		chk8({7'h00, timer_zero_overflow}, 8'h00);
		wr(dtc_pkg::ADDR_CTRL, 8'hA0);
		ack(1'b1);
		chk8({6'h00, timer_one_overflow, timer_zero_overflow}, 8'h01);
		wr(dtc_pkg::ADDR_CTRL, 8'h00);
		chk8({6'h00, timer_one_overflow, timer_zero_overflow}, 8'h00);
	endtask

	task automatic t_reload();
		setup(8'h02, 8'hFE, 8'hF0);
		wr(dtc_pkg::ADDR_CTRL, 8'h10);
		wait_flag(1'b0, 30);
		rd_chk(dtc_pkg::ADDR_HI_ZERO, 8'hF0, 8'hFF);
		rd_chk(dtc_pkg::ADDR_LOW_ZERO, 8'hF0, 8'hF8);
	endtask

	task automatic t_counter();
		setup(8'h05, 8'h00, 8'h00);
		wr(dtc_pkg::ADDR_CTRL, 8'h10);
		i_dtc_far_model.fall_edges(5, 2 * MC);
		repeat (40) @(posedge clk);
		rd_chk(dtc_pkg::ADDR_LOW_ZERO, 8'h05, 8'hFF);
		rd_chk(dtc_pkg::ADDR_HI_ZERO, 8'h00, 8'hFF);
	endtask

	task automatic t_toggle();
		setup(8'h02, 8'hFE, 8'hFE);
		wr(dtc_pkg::ADDR_TOGGLE, 8'h01);
		chk8({6'h00, pz_i, pz_oe}, 8'h03);
		wr(dtc_pkg::ADDR_CTRL, 8'h10);
		wait_flag(1'b0, 30);
		@(posedge clk);
		chk8({7'h00, pz_i}, 8'h00);
		ack(1'b0);
		wait_flag(1'b0, 20);
		@(posedge clk);
		chk8({7'h00, pz_i}, 8'h01);
		wr(dtc_pkg::ADDR_TOGGLE, 8'h00);
	endtask

	task automatic t_split();
		logic lvl;
		setup(8'h00, 8'h00, 8'hFE);
		wr(dtc_pkg::ADDR_HI_ONE, 8'hF0);
		wr(dtc_pkg::ADDR_LOW_ONE, 8'hF0);
		wr(dtc_pkg::ADDR_TOGGLE, 8'h02);
		chk8({6'h00, po_i, po_oe}, 8'h03);
		wr(dtc_pkg::ADDR_MODE, 8'h23);
		wr(dtc_pkg::ADDR_CTRL, 8'h40);
		wait_flag(1'b1, 30);
		repeat (300) @(posedge clk);
		chk8(baud_gap, 8'(16 * MC));
		// Exactly one timer one overflow falls in any reload period
		lvl = po_i;
		repeat (16 * MC) @(posedge clk);
		chk8({7'h00, po_i}, {7'h00, ~lvl});
		rd_chk(dtc_pkg::ADDR_LOW_ZERO, 8'h00, 8'hFF);
		wr(dtc_pkg::ADDR_MODE, 8'h33);
		wr(dtc_pkg::ADDR_LOW_ONE, 8'h55);
		repeat (30) @(posedge clk);
		rd_chk(dtc_pkg::ADDR_LOW_ONE, 8'h55, 8'hFF);
	endtask

	// Verdict and end of run
	task automatic wrap_up();
		if (n_fail == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		nrst = 1'b0;
		reg_addr = 3'h0;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		ack_zero = 1'b0;
		ack_one = 1'b0;
		n_fail = 0;
		check_count = 0;
		cycles = 0;
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		t_reset();
		t_gate_run();
		t_gate_one();
		t_mode0();
		t_flags();
		t_reload();
		t_counter();
		t_toggle();
		t_split();
		wrap_up();
	end
endmodule

`default_nettype wire
